// ---- core/iqr_defs.vh ----
// iqr_defs.vh: register offsets, field positions and reset values
// assumes inclusion by bare name from the core design files
`ifndef IQR_DEFS_VH
`define IQR_DEFS_VH
// ****************************************
// register byte offsets (64-bit regs as two words)
// ****************************************
`define IQR_OFF_TAIL_LO    12'h088
`define IQR_OFF_TAIL_HI    12'h08c
`define IQR_OFF_BASE_LO    12'h090
`define IQR_OFF_BASE_HI    12'h094
`define IQR_OFF_WSTAT      12'h09c
`define IQR_OFF_CTRL       12'h0c0
`define IQR_OFF_HEAD       12'h0c4
`define IQR_OFF_IRQ_STAT   12'h0c8
`define IQR_OFF_IRQ_CLR    12'h0cc
`define IQR_OFF_IRQ_EN     12'h0d0
// ****************************************
// field positions
// ****************************************
`define IQR_TAIL_MSB       18
`define IQR_TAIL_LSB       4
`define IQR_BASE_LSB       12
`define IQR_DW_BIT         11
`define IQR_QS_MSB         2
`define IQR_CTRL_EN_BIT    0
`define IQR_IRQ_DONE_BIT   0
`define IQR_IRQ_ERR_BIT    1
`define IQR_IRQ_W          2
`define IQR_RST_WORD       32'h0000_0000
`endif

// ---- core/iqr_apb_slave.v ----
// iqr_apb_slave.v: zero-wait apb slave front end, decodes strobes
// assumes psel/penable from an apb master on the same clock
`default_nettype none
module iqr_apb_slave (
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [11:0] map_addr,
  output wire        pready,
  output wire        wr_hit,
  output wire        rd_hit
);
  // ****************************************
  // write strobe in access phase, read strobe in setup and access phase, always ready
  // ****************************************
  assign pready = 1'b1;
  assign wr_hit = psel & penable & pwrite & (paddr == map_addr);
  assign rd_hit = psel & ~pwrite & (paddr == map_addr);
endmodule // iqr_apb_slave
`default_nettype wire

// ---- core/iqr_sync.v ----
// iqr_sync.v: two flip-flop level synchroniser
// assumes async input, clk domain destination
`default_nettype none
module iqr_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output wire dout
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
    end
  end
  assign dout = s2_ff;
endmodule // iqr_sync
`default_nettype wire

// ---- core/iqr_regs.v ----
// iqr_regs.v: invalidation queue register bank with head tracking
// assumes apb master on clk, fetch engine on clk, async pin straps
//
// Chosen here: the APB slave port.
`default_nettype none
`include "iqr_defs.vh"
module iqr_regs #(
  parameter HOST_ADDRESS_WIDTH = 48
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        sticky_nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        qi_supported_pin,
  input  wire        scalable_xlate_supported_pin,
  input  wire        abort_dma_supported_pin,
  input  wire        fetch_done,
  input  wire        wait_irq_done,
  output wire        desc_pending,
  output wire [63:0] queue_base_address,
  output wire        descriptor_width,
  output wire [2:0]  queue_size_code,
  output wire [15:0] queue_entries,
  output wire [14:0] head_offset,
  output wire        queue_error,
  output wire        event_pending,
  output wire        irq
);
  // ****************************************
  // reset release and strap synchronisers
  // ****************************************
  reg  r1_ff;
  reg  rst_n_ff;
  wire qi_sup;
  wire sm_sup;
  wire ad_sup;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r1_ff    <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      r1_ff    <= 1'b1;
      rst_n_ff <= r1_ff;
    end
  end
  iqr_sync u_sync_qi (.clk(clk), .rst_n(rst_n_ff),
    .din(qi_supported_pin), .dout(qi_sup));
  iqr_sync u_sync_sm (.clk(clk), .rst_n(rst_n_ff),
    .din(scalable_xlate_supported_pin), .dout(sm_sup));
  iqr_sync u_sync_ad (.clk(clk), .rst_n(rst_n_ff),
    .din(abort_dma_supported_pin), .dout(ad_sup));

  // ****************************************
  // apb decode
  // ****************************************
  wire w_tl, w_th, w_bl, w_bh, w_ws, w_ct, w_hd, w_is, w_ic, w_ie;
  wire r_tl, r_th, r_bl, r_bh, r_ws, r_ct, r_hd, r_is, r_ic, r_ie;
  wire any_rd;
  // one decoder per word keeps each hit a simple compare
  iqr_apb_slave u_tl (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .map_addr (`IQR_OFF_TAIL_LO),
    .pready   (pready),
    .wr_hit   (w_tl),
    .rd_hit   (r_tl)
  );
  iqr_apb_slave u_th (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .map_addr (`IQR_OFF_TAIL_HI),
    .pready   (),
    .wr_hit   (w_th),
    .rd_hit   (r_th)
  );
  iqr_apb_slave u_bl (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .map_addr (`IQR_OFF_BASE_LO),
    .pready   (),
    .wr_hit   (w_bl),
    .rd_hit   (r_bl)
  );
  iqr_apb_slave u_bh (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .map_addr (`IQR_OFF_BASE_HI),
    .pready   (),
    .wr_hit   (w_bh),
    .rd_hit   (r_bh)
  );
  iqr_apb_slave u_ws (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .map_addr (`IQR_OFF_WSTAT),
    .pready   (),
    .wr_hit   (w_ws),
    .rd_hit   (r_ws)
  );
  iqr_apb_slave u_ct (.psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .map_addr(`IQR_OFF_CTRL), .pready(),
    .wr_hit(w_ct), .rd_hit(r_ct));
  iqr_apb_slave u_hd (.psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .map_addr(`IQR_OFF_HEAD), .pready(),
    .wr_hit(w_hd), .rd_hit(r_hd));
  iqr_apb_slave u_is (.psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .map_addr(`IQR_OFF_IRQ_STAT), .pready(),
    .wr_hit(w_is), .rd_hit(r_is));
  iqr_apb_slave u_ic (.psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .map_addr(`IQR_OFF_IRQ_CLR), .pready(),
    .wr_hit(w_ic), .rd_hit(r_ic));
  iqr_apb_slave u_ie (.psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .map_addr(`IQR_OFF_IRQ_EN), .pready(),
    .wr_hit(w_ie), .rd_hit(r_ie));
  assign any_rd = r_tl | r_th | r_bl | r_bh | r_ws | r_ct | r_hd |
                  r_is | r_ic | r_ie;
  // unmapped addresses answer with an error, not silently
  assign pslverr = psel & penable & ~(any_rd | w_tl | w_th | w_bl |
                   w_bh | w_ws | w_ct | w_hd | w_is | w_ic | w_ie);

  // ****************************************
  // configuration registers
  // ****************************************
  reg  [14:0] tail_offset_ff;
  reg  [63:12] base_ff;
  reg         dw_ff;
  reg  [2:0]  qs_ff;
  reg         qi_en_ff;
  reg  [1:0]  irq_en_ff;
  wire [63:0] base_mask;
  assign base_mask = (HOST_ADDRESS_WIDTH >= 64) ? {64{1'b1}} :
                     ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1);
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tail_offset_ff <= 15'h0;
      base_ff        <= 52'h0;
      dw_ff          <= 1'b0;
      qs_ff          <= 3'h0;
      qi_en_ff       <= 1'b0;
      irq_en_ff      <= 2'h0;
    end else begin
      if (w_tl && qi_sup)
        tail_offset_ff <= pwdata[`IQR_TAIL_MSB:`IQR_TAIL_LSB];
      if (w_bl && qi_sup) begin
        base_ff[31:12] <= pwdata[31:12] & base_mask[31:12];
        dw_ff          <= pwdata[`IQR_DW_BIT];
        qs_ff          <= pwdata[`IQR_QS_MSB:0];
      end
      if (w_bh && qi_sup)
        base_ff[63:32] <= pwdata & base_mask[63:32];
      if (w_ct)
        qi_en_ff <= pwdata[`IQR_CTRL_EN_BIT] & qi_sup;
      if (w_ie)
        irq_en_ff <= pwdata[1:0];
    end
  end
  assign queue_base_address = {base_ff, 12'h000};
  assign descriptor_width   = dw_ff;
  assign queue_size_code    = qs_ff;
  // entries: 2^(X+8) or 2^(X+7), pow-2 mask derived below
  assign queue_entries = dw_ff ? (16'h0080 << qs_ff)
                               : (16'h0100 << qs_ff);

  // ****************************************
  // error detection
  // ****************************************
  wire err_tail;
  wire err_dw;
  assign err_tail = dw_ff & tail_offset_ff[0];
  assign err_dw   = dw_ff & ~sm_sup & ~ad_sup;
  assign queue_error = qi_sup & (err_tail | err_dw);

  // ****************************************
  // head offset tracking
  // ****************************************
  reg  [14:0] head_ff;
  reg  [14:0] nxt_head;
  wire [14:0] step;
  wire [14:0] wrap_mask;
  // head counts 16-byte units; queue is 2^(X+8) units of 16 bytes
  assign step      = dw_ff ? 15'h0002 : 15'h0001;
  assign wrap_mask = (15'h0100 << qs_ff) - 15'h0001;
  assign desc_pending = qi_en_ff & (head_ff != tail_offset_ff) &
                        ~queue_error;
  always @* begin
    nxt_head = head_ff;
    if (!qi_en_ff)
      nxt_head = 15'h0;
    else if (fetch_done && desc_pending)
      nxt_head = (head_ff + step) & wrap_mask;
  end
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff)
      head_ff <= 15'h0;
    else
      head_ff <= nxt_head;
  end
  assign head_offset = head_ff;

  // ****************************************
  // completion flag, sticky domain
  // ****************************************
  reg  done_ff;
  reg  ev_pend_ff;
  wire done_set;
  wire done_clr;
  assign done_set = wait_irq_done & qi_sup;
  assign done_clr = w_ws & pwdata[0];
  // sticky reset only; set wins over a simultaneous clear
  always @(posedge clk or negedge sticky_nrst) begin
    if (!sticky_nrst)
      done_ff <= 1'b0;
    else if (done_set)
      done_ff <= 1'b1;
    else if (done_clr)
      done_ff <= 1'b0;
  end
  // new condition only on a 0 -> 1 transition of the flag
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff)
      ev_pend_ff <= 1'b0;
    else if (done_set && !done_ff)
      ev_pend_ff <= 1'b1;
    else if (!done_ff || (done_clr && !done_set))
      ev_pend_ff <= 1'b0;
  end
  assign event_pending = ev_pend_ff;

  // ****************************************
  // interrupt status, clear and enable
  // ****************************************
  reg  [1:0] irq_stat_ff;
  wire [1:0] irq_ev;
  assign irq_ev = {queue_error, done_set & ~done_ff};
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff)
      irq_stat_ff <= 2'h0;
    else
      irq_stat_ff <= irq_ev | (irq_stat_ff & ~({2{w_ic}} & pwdata[1:0]));
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ****************************************
  // read data mux
  // ****************************************
  always @* begin
    prdata = `IQR_RST_WORD;
    if (r_tl && qi_sup)
      prdata = {13'h0, tail_offset_ff, 4'h0};
    else if (r_bl && qi_sup)
      prdata = {base_ff[31:12], dw_ff, 8'h0, qs_ff};
    else if (r_bh && qi_sup)
      prdata = base_ff[63:32];
    else if (r_ws && qi_sup)
      prdata = {31'h0, done_ff};
    else if (r_ct)
      prdata = {28'h0, sm_sup, ad_sup, qi_sup, qi_en_ff};
    else if (r_hd)
      prdata = {13'h0, head_ff, 4'h0};
    else if (r_is)
      prdata = {30'h0, irq_stat_ff};
    else if (r_ie)
      prdata = {30'h0, irq_en_ff};
  end
endmodule // iqr_regs
`default_nettype wire

// ---- tb/iqr_regs_checker.sv ----
// iqr_regs_checker.sv: concurrent checks on the iqr_regs ports
// assumes bind from the testbench top, single clock domain
`default_nettype none
module iqr_regs_checker #(
  parameter int HOST_ADDRESS_WIDTH = 48
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        sticky_nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        scalable_xlate_supported_pin,
  input wire logic        abort_dma_supported_pin,
  input wire logic        fetch_done,
  input wire logic        wait_irq_done,
  input wire logic        desc_pending,
  input wire logic [63:0] queue_base_address,
  input wire logic        descriptor_width,
  input wire logic [2:0]  queue_size_code,
  input wire logic [15:0] queue_entries,
  input wire logic [14:0] head_offset,
  input wire logic        queue_error,
  input wire logic        event_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // expected head step, wrap in 16-byte units
  // ****************************************
  logic [15:0] units;
  logic [15:0] wrap_mask;
  logic [14:0] head_next;
  assign units = descriptor_width ? {queue_entries[14:0], 1'b0} : queue_entries;
  assign wrap_mask = units - 16'h1;
  assign head_next = (head_offset + {13'h0, descriptor_width, ~descriptor_width})
                     & wrap_mask[14:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_entries_size: assert property (queue_entries == (descriptor_width ?
    16'h1 << (queue_size_code + 4'd7) : 16'h1 << (queue_size_code + 4'd8)))
    else $error("entry count does not match size code");
  a_base_align: assert property (queue_base_address[11:0] == 12'h000)
    else $error("base address not 4k aligned");
  a_base_haw: assert property (queue_base_address[63:HOST_ADDRESS_WIDTH] == '0)
    else $error("base bits above address width set");
  a_width_err: assert property (descriptor_width
    && !scalable_xlate_supported_pin && !abort_dma_supported_pin
    && $past(!scalable_xlate_supported_pin && !abort_dma_supported_pin, 3)
    |-> queue_error) else $error("wide descriptors not flagged");
  a_done_pending: assert property (wait_irq_done |=> event_pending)
    else $error("pending not raised on completion");
  a_pending_hold: assert property (event_pending && sticky_nrst
    && !(psel && penable && pwrite) |=> event_pending)
    else $error("pending dropped without a clear");
  a_head_step: assert property (fetch_done && desc_pending
    |=> head_offset == $past(head_next))
    else $error("head did not step and wrap");
endmodule // iqr_regs_checker
`default_nettype wire

// ---- tb/tb_invalidation_queue_regs.sv ----
// tb_invalidation_queue_regs.sv: self-checking bench for iqr_regs
// assumes iqr_defs.vh on the include path, apb master in this bench
`default_nettype none
`include "iqr_defs.vh"
module tb_invalidation_queue_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus, read notes and monitor
  // ****************************************
  logic clk, nrst, sticky_nrst, psel, penable, pwrite, pready, pslverr;
  logic qi_pin, sc_pin, ab_pin, fetch_done, wait_irq_done, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [33:0] notes[$];
  logic [11:0] offs[5] = '{`IQR_OFF_TAIL_LO, `IQR_OFF_TAIL_HI,
    `IQR_OFF_BASE_LO, `IQR_OFF_BASE_HI, `IQR_OFF_WSTAT};
  int bad_count = 0, samples_checked = 0, seed = 91, cycles = 0;
  iqr_regs u_iqr_regs (.clk(clk), .nrst(nrst), .sticky_nrst(sticky_nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qi_supported_pin(qi_pin), .scalable_xlate_supported_pin(sc_pin),
    .abort_dma_supported_pin(ab_pin), .fetch_done(fetch_done),
    .wait_irq_done(wait_irq_done), .desc_pending(), .queue_base_address(),
    .descriptor_width(), .queue_size_code(), .queue_entries(),
    .head_offset(), .queue_error(), .event_pending(), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  // reads compare {pslverr, irq, prdata} with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      samples_checked++;
      if ({pslverr, irq, prdata} !== notes[0]) begin
        bad_count++;
        $display("BAD read %h exp %h got %h", paddr, notes[0],
                 {pslverr, irq, prdata});
      end
      void'(notes.pop_front());
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [1:0] f, input logic [31:0] e);
    notes.push_back({f, e});
    apb(1'b0, a, 32'h0);
  endtask
  task pulse(input logic fetch);
    @(posedge clk);
    if (fetch) fetch_done <= 1'b1;
    else wait_irq_done <= 1'b1;
    @(posedge clk);
    fetch_done <= 1'b0;
    wait_irq_done <= 1'b0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, fetch_done, wait_irq_done, sc_pin, ab_pin} = '0;
    {paddr, pwdata, nrst, sticky_nrst} = '0;
    qi_pin = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    sticky_nrst <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (offs[i]) rd(offs[i], 2'b00, 32'h0);
    rd(12'h0f0, 2'b10, 32'h0);
    wr(`IQR_OFF_CTRL, 32'h1);
    repeat (4) begin
      v = $random(seed);
      wr(`IQR_OFF_TAIL_LO, v);
      rd(`IQR_OFF_TAIL_LO, 2'b00, v & 32'h0007fff0);
    end
    wr(`IQR_OFF_BASE_LO, 32'hfffff803);
    rd(`IQR_OFF_BASE_LO, 2'b00, 32'hfffff803);
    wr(`IQR_OFF_BASE_HI, 32'hffffffff);
    rd(`IQR_OFF_BASE_HI, 2'b00, 32'h0000ffff);
    sc_pin <= 1'b1;
    wr(`IQR_OFF_TAIL_LO, 32'h20);
    wr(`IQR_OFF_IRQ_CLR, 32'h2);
    rd(`IQR_OFF_IRQ_STAT, 2'b00, 32'h0);
    wr(`IQR_OFF_TAIL_LO, 32'h30);
    rd(`IQR_OFF_IRQ_STAT, 2'b00, 32'h2);
    wr(`IQR_OFF_TAIL_LO, 32'h20);
    wr(`IQR_OFF_IRQ_CLR, 32'h2);
    pulse(1'b1);
    rd(`IQR_OFF_HEAD, 2'b00, 32'h20);
    // size 0, wide: 127 more steps of two units wrap the head to 0
    wr(`IQR_OFF_BASE_LO, 32'hfffff800);
    wr(`IQR_OFF_TAIL_LO, 32'h0);
    repeat (127) pulse(1'b1);
    rd(`IQR_OFF_HEAD, 2'b00, 32'h0);
    wr(`IQR_OFF_TAIL_LO, 32'h40);
    pulse(1'b1);
    wr(`IQR_OFF_CTRL, 32'h0);
    rd(`IQR_OFF_HEAD, 2'b00, 32'h0);
    wr(`IQR_OFF_IRQ_EN, 32'h1);
    pulse(1'b0);
    rd(`IQR_OFF_WSTAT, 2'b01, 32'h1);
    wr(`IQR_OFF_IRQ_CLR, 32'h1);
    rd(`IQR_OFF_IRQ_STAT, 2'b00, 32'h0);
    pulse(1'b0);
    wr(`IQR_OFF_WSTAT, 32'h0);
    rd(`IQR_OFF_WSTAT, 2'b00, 32'h1);
    wr(`IQR_OFF_IRQ_EN, 32'h0);
    rd(`IQR_OFF_IRQ_STAT, 2'b00, 32'h0);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`IQR_OFF_WSTAT, 2'b00, 32'h1);
    wr(`IQR_OFF_WSTAT, 32'h1);
    rd(`IQR_OFF_WSTAT, 2'b00, 32'h0);
    qi_pin <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`IQR_OFF_TAIL_LO, 32'h40);
    wr(`IQR_OFF_BASE_LO, 32'h1000);
    rd(`IQR_OFF_TAIL_LO, 2'b00, 32'h0);
    rd(`IQR_OFF_BASE_LO, 2'b00, 32'h0);
    print_verdict();
  end
endmodule // tb_invalidation_queue_regs
bind iqr_regs iqr_regs_checker #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) u_iqr_regs_checker (
  .clk(clk), .nrst(nrst), .sticky_nrst(sticky_nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready),
  .scalable_xlate_supported_pin(scalable_xlate_supported_pin),
  .abort_dma_supported_pin(abort_dma_supported_pin),
  .fetch_done(fetch_done), .wait_irq_done(wait_irq_done),
  .desc_pending(desc_pending), .queue_base_address(queue_base_address),
  .descriptor_width(descriptor_width), .queue_size_code(queue_size_code),
  .queue_entries(queue_entries), .head_offset(head_offset),
  .queue_error(queue_error), .event_pending(event_pending));
`default_nettype wire
